// >>> pkg/mqf_map.svh
// Purpose: offsets, field positions, reset values and defaults of the status flag block
// Assumes: one clock, APB register access
// Notes:   definitions only
//
// Functional notes
// - active almost-empty output follows the read-selected queue; all queues tracked.
// - almost-empty boundary programmable, or default offset of 8 or 128.
// - each queue offset settable from zero to its depth, independently.
// - after read-queue selection, output shows new queue on third edge.
// - read crossing boundary drives output low two cycles later.
// - write lifting selected queue drives output high one cycle after skew window.
// - skew not met adds one cycle to the flag going high.
// - output changes only on clock edges; unselected queues update internally.
// - mode input low at master reset gives direct bus, high gives polled.
// - direct mode strobe captures low write-address bits as status word.
// - bus shows selected word one cycle later; bit k is queue 8w+k.
// - bus bits of unconfigured queues are don't-care.
// - bit of queue touched during word switch may lag one cycle.
// - eight or fewer queues in direct mode: queues 0 to 7 shown continuously.
// - upper write-address bits must match identity inputs to select device.
// - polled mode loads next word each edge, cycling ceil(queues/8) words.
// - polled master takes the bus once master reset goes high.
// - sync high for the cycle the first word is on the bus.
// - no token means bus released; after last word token passes on.
`ifndef MQF_MAP_SVH
`define MQF_MAP_SVH
`define MQF_OFF_CTRL    8'h00
`define MQF_OFF_QSEL    8'h04
`define MQF_OFF_AEOFF   8'h08
`define MQF_OFF_AFOFF   8'h0C
`define MQF_OFF_DEPTH   8'h10
`define MQF_OFF_COUNT   8'h14
`define MQF_OFF_STATUS  8'h18
`define MQF_CTRL_NQ_MSB 7
`define MQF_CTRL_DEF    8
`define MQF_CTRL_SKEW   9
`define MQF_CTRL_DEFHI  10
`define MQF_RST_CTRL    11'h080
`define MQF_DEF_LO      16'h0008
`define MQF_DEF_HI      16'h0080
`define MQF_RST_DEPTH   16'h0400
`define MQF_ID_MSB      7
`define MQF_ID_LSB      5
`define MQF_GRP_SHIFT   3
`define MQF_GRP_ROUND   9'h007
`define MQF_SEL_LAT     2
`endif

// >>> pkg/mqf_pkg.sv
// Purpose: shared types of the status flag block
// Assumes: nothing
// Notes:   constants live in mqf_map.svh
package mqf_pkg;
  // bus mode latched at master reset
  typedef enum logic [0:0] {
    MQF_DIRECT = 1'b0,
    MQF_POLLED = 1'b1
  } mqf_mode_type;
  // token holding state for the polled ring
  typedef enum logic [0:0] {
    MQF_TOK_IDLE = 1'b0,
    MQF_TOK_OWN  = 1'b1
  } mqf_tok_type;
endpackage : mqf_pkg

// >>> hw/mqf_status_flags.sv
// Purpose: per-queue almost-empty tracking and almost-full status bus
// Assumes: read and write ports synchronous to pclk
// Notes:   bus output enable is active low
`timescale 1ns/100ps
`include "mqf_map.svh"
module mqf_status_flags #(
  parameter int NQ = 128,
  parameter int QW = 7,
  parameter int CW = 16,
  parameter int WW = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        master_reset_n,
  input  wire logic        flag_bus_mode_sel,
  input  wire logic        master_strap,
  input  wire logic        dev_id_bit0,
  input  wire logic        dev_id_bit1,
  input  wire logic        dev_id_bit2,
  input  wire logic [7:0]  read_queue_addr,
  input  wire logic        read_addr_enable,
  input  wire logic        rd_en,
  input  wire logic [7:0]  write_queue_addr,
  input  wire logic        write_addr_enable,
  input  wire logic        wr_en,
  input  wire logic        full_status_strobe,
  input  wire logic        token_in,
  output logic             active_almost_empty_n,
  output logic [7:0]       full_status_bus,
  output logic             full_status_bus_oe_n,
  output logic             status_bus_sync,
  output logic             token_out
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [CW-1:0]        cnt_q    [NQ];
  logic [CW-1:0]        ae_off_q [NQ];
  logic [CW-1:0]        af_off_q [NQ];
  logic [CW-1:0]        depth_q  [NQ];
  logic [10:0]          ctrl_q;
  logic [QW-1:0]        qsel_q;
  logic [31:0]          prdata_q;
  logic [QW-1:0]        sel_p1_q;
  logic [QW-1:0]        cur_rq_q;
  logic [QW-1:0]        wq_q;
  logic                 ae_s1_q;
  logic                 ae_raw_q;
  logic                 ae_n_q;
  mqf_pkg::mqf_mode_type mode_q;
  mqf_pkg::mqf_tok_type  tok_q;
  logic [WW-1:0]        word_q;
  logic [WW-1:0]        pw_q;
  logic                 own_q;
  logic [7:0]           bus_q;
  logic                 drv_q;
  logic                 sync_q;
  logic                 tok_out_q;
  logic                 sel_take_q;
  logic [1:0]           sel_age_q;

  // ------------------------------------------------------------
  // flag functions
  // ------------------------------------------------------------
  // offset in force for a queue: programmed or one of two defaults
  function automatic logic [CW-1:0] ae_lim(input logic [QW-1:0] q);
    if (ctrl_q[`MQF_CTRL_DEF])
      ae_lim = ctrl_q[`MQF_CTRL_DEFHI] ? `MQF_DEF_HI : `MQF_DEF_LO;
    else
      ae_lim = ae_off_q[q];
  endfunction : ae_lim

  // true while the queue sits at or below its boundary
  function automatic logic ae_of(input logic [QW-1:0] q);
    ae_of = cnt_q[q] <= ae_lim(q);
  endfunction : ae_of

  // true while the queue holds depth minus offset words or more
  function automatic logic af_of(input logic [QW-1:0] q);
    af_of = ({1'b0, cnt_q[q]} + {1'b0, af_off_q[q]}) >= {1'b0, depth_q[q]};
  endfunction : af_of

  // active-low status of the eight queues of one word
  function automatic logic [7:0] word_bits(input logic [WW-1:0] w);
    word_bits = 8'h00;
    for (int k = 0; k < 8; k++) begin
      word_bits[k] = ~af_of({w, 3'(k)});
    end
  endfunction : word_bits

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire             apb_setup  = psel & ~penable;
  wire             apb_wr     = psel & penable & pwrite;
  wire             hit_ctrl   = paddr == `MQF_OFF_CTRL;
  wire             hit_qsel   = paddr == `MQF_OFF_QSEL;
  wire             hit_aeoff  = paddr == `MQF_OFF_AEOFF;
  wire             hit_afoff  = paddr == `MQF_OFF_AFOFF;
  wire             hit_depth  = paddr == `MQF_OFF_DEPTH;
  wire             hit_count  = paddr == `MQF_OFF_COUNT;
  wire             hit_status = paddr == `MQF_OFF_STATUS;
  wire             hit_any    = hit_ctrl | hit_qsel | hit_aeoff | hit_afoff | hit_depth | hit_count | hit_status;
  wire [7:0]       nq         = ctrl_q[`MQF_CTRL_NQ_MSB:0];
  wire [8:0]       nw_raw     = ({1'b0, nq} + `MQF_GRP_ROUND) >> `MQF_GRP_SHIFT;
  wire [WW-1:0]    last_word  = (nw_raw == 9'h000) ? '0 : WW'(nw_raw - 9'h001);
  wire             small_cfg  = nq <= 8'h08;
  wire [2:0]       my_id      = {dev_id_bit2, dev_id_bit1, dev_id_bit0};
  wire             id_match   = write_queue_addr[`MQF_ID_MSB:`MQF_ID_LSB] == my_id;
  wire [QW-1:0]    rq_addr    = read_queue_addr[QW-1:0];
  wire [QW-1:0]    wq_addr    = write_queue_addr[QW-1:0];
  wire             ae_now     = ae_of(cur_rq_q);
  wire             last_pw    = pw_q == last_word;
  wire             poll_start = (tok_q == mqf_pkg::MQF_TOK_IDLE) & token_in;
  wire             poll_run   = (tok_q == mqf_pkg::MQF_TOK_OWN) | poll_start;
  wire             polled     = mode_q == mqf_pkg::MQF_POLLED;

  // read mux; unmapped addresses read zero and flag an error
  logic [31:0] rd_mux;
  always_comb begin
    if (hit_ctrl)
      rd_mux = {21'h000000 & 21'h0, ctrl_q};
    else if (hit_qsel)
      rd_mux = {{(32-QW){1'b0}}, qsel_q};
    else if (hit_aeoff)
      rd_mux = {{(32-CW){1'b0}}, ae_off_q[qsel_q]};
    else if (hit_afoff)
      rd_mux = {{(32-CW){1'b0}}, af_off_q[qsel_q]};
    else if (hit_depth)
      rd_mux = {{(32-CW){1'b0}}, depth_q[qsel_q]};
    else if (hit_count)
      rd_mux = {{(32-CW){1'b0}}, cnt_q[qsel_q]};
    else if (hit_status)
      rd_mux = {16'h0000, 3'h0, mode_q, tok_q, own_q, ae_n_q, 1'b0, 4'(word_q), 4'(pw_q)};
    else
      rd_mux = 32'h00000000;
  end

  // ------------------------------------------------------------
  // apb slave: zero-wait, read data caught in the setup cycle
  // ------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata  = prdata_q;

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata_q <= 32'h00000000;
    else if (apb_setup & ~pwrite)
      prdata_q <= rd_mux;
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `MQF_RST_CTRL;
      qsel_q <= '0;
    end else if (apb_wr & hit_ctrl) begin
      ctrl_q <= pwdata[10:0];
    end else if (apb_wr & hit_qsel) begin
      qsel_q <= pwdata[QW-1:0];
    end
  end

  // per-queue offsets and depth; offsets clamp at depth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NQ; i++) begin
        ae_off_q[i] <= `MQF_DEF_LO;
        af_off_q[i] <= `MQF_DEF_LO;
        depth_q[i]  <= `MQF_RST_DEPTH;
      end
    end else if (apb_wr & hit_aeoff) begin
      ae_off_q[qsel_q] <= (pwdata[CW-1:0] > depth_q[qsel_q]) ? depth_q[qsel_q] : pwdata[CW-1:0];
    end else if (apb_wr & hit_afoff) begin
      af_off_q[qsel_q] <= (pwdata[CW-1:0] > depth_q[qsel_q]) ? depth_q[qsel_q] : pwdata[CW-1:0];
    end else if (apb_wr & hit_depth) begin
      depth_q[qsel_q] <= pwdata[CW-1:0];
    end
  end

  // ------------------------------------------------------------
  // queue occupancy, tracked for every queue
  // ------------------------------------------------------------
  // overflow and underflow are dropped so a status never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NQ; i++)
        cnt_q[i] <= '0;
    end else if (!master_reset_n) begin
      for (int i = 0; i < NQ; i++)
        cnt_q[i] <= '0;
    end else begin
      for (int i = 0; i < NQ; i++) begin
        if ((wr_en && wq_q == QW'(i) && cnt_q[i] < depth_q[i]) &&
            !(rd_en && cur_rq_q == QW'(i) && cnt_q[i] != '0))
          cnt_q[i] <= cnt_q[i] + 1'b1;
        else if (!(wr_en && wq_q == QW'(i) && cnt_q[i] < depth_q[i]) &&
                 (rd_en && cur_rq_q == QW'(i) && cnt_q[i] != '0))
          cnt_q[i] <= cnt_q[i] - 1'b1;
      end
    end
  end

  // write queue selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wq_q <= '0;
    else if (write_addr_enable)
      wq_q <= wq_addr;
  end

  // ------------------------------------------------------------
  // read side: active almost-empty flag
  // ------------------------------------------------------------
  // one stage of selection pipeline plus two flag stages lands the
  // new queue on the third edge after selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_p1_q <= '0;
      cur_rq_q <= '0;
    end else if (read_addr_enable) begin
      sel_p1_q <= rq_addr;
    end else begin
      cur_rq_q <= sel_p1_q;
    end
  end

  // double registered flag; a late-skew write holds release one more cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ae_raw_q <= 1'b1;
      ae_s1_q  <= 1'b1;
      ae_n_q   <= 1'b0;
    end else begin
      ae_raw_q <= ae_now;
      ae_s1_q  <= ae_now | (ctrl_q[`MQF_CTRL_SKEW] & ae_raw_q);
      ae_n_q   <= ~ae_s1_q;
    end
  end
  assign active_almost_empty_n = ae_n_q;

  // ------------------------------------------------------------
  // write side: almost-full status bus
  // ------------------------------------------------------------
  // mode and master strap caught while the master reset is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= mqf_pkg::MQF_DIRECT;
    end else if (!master_reset_n) begin
      mode_q <= flag_bus_mode_sel ? mqf_pkg::MQF_POLLED : mqf_pkg::MQF_DIRECT;
    end
  end

  // direct mode word select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= '0;
      own_q  <= 1'b0;
    end else if (!master_reset_n) begin
      word_q <= '0;
      own_q  <= 1'b0;
    end else if (full_status_strobe && !write_addr_enable) begin
      word_q <= write_queue_addr[WW-1:0];
      own_q  <= id_match;
    end
  end

  // polled ring: token taken on token_in, passed after last word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tok_q     <= mqf_pkg::MQF_TOK_IDLE;
      pw_q      <= '0;
      tok_out_q <= 1'b0;
    end else if (!master_reset_n) begin
      tok_q     <= (flag_bus_mode_sel & master_strap) ? mqf_pkg::MQF_TOK_OWN : mqf_pkg::MQF_TOK_IDLE;
      pw_q      <= '0;
      tok_out_q <= 1'b0;
    end else if (polled && poll_run) begin
      pw_q      <= last_pw ? '0 : pw_q + 1'b1;
      tok_q     <= last_pw ? mqf_pkg::MQF_TOK_IDLE : mqf_pkg::MQF_TOK_OWN;
      tok_out_q <= last_pw;
    end else begin
      tok_out_q <= 1'b0;
    end
  end

  // bus register: one cycle after selection, lag on a coinciding access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_q  <= 8'hFF;
      drv_q  <= 1'b0;
      sync_q <= 1'b0;
    end else if (!master_reset_n) begin
      bus_q  <= 8'hFF;
      drv_q  <= 1'b0;
      sync_q <= 1'b0;
    end else if (polled) begin
      bus_q  <= word_bits(pw_q);
      drv_q  <= poll_run;
      sync_q <= poll_run & (pw_q == '0);
    end else if (small_cfg) begin
      bus_q  <= word_bits('0);
      drv_q  <= 1'b1;
      sync_q <= 1'b0;
    end else begin
      bus_q  <= word_bits(word_q);
      drv_q  <= own_q;
      sync_q <= 1'b0;
    end
  end

  assign full_status_bus      = bus_q;
  assign full_status_bus_oe_n = ~drv_q;
  assign status_bus_sync      = sync_q;
  assign token_out            = tok_out_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking a_clk @(posedge pclk); endclocking
  default disable iff (!presetn);

  // helper: read selection age, counts edges since last select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_take_q <= 1'b0;
      sel_age_q  <= 2'h0;
    end else begin
      sel_take_q <= read_addr_enable;
      sel_age_q  <= read_addr_enable ? 2'h0 : ((sel_age_q == 2'h3) ? 2'h3 : sel_age_q + 2'h1);
    end
  end

  a_sel_queue_lands: assert property (
    read_addr_enable ##1 !read_addr_enable |-> ##1 cur_rq_q == $past(read_queue_addr[QW-1:0], 2))
    else $error("read queue not current two edges after select");

  a_flag_follows_queue: assert property (
    !ctrl_q[`MQF_CTRL_SKEW] && $stable(cur_rq_q) |-> ##2 active_almost_empty_n == !$past(ae_now, 2))
    else $error("active flag does not show selected queue");

  a_read_low_two: assert property (
    ae_now && !$past(ae_now) |-> ##2 !active_almost_empty_n)
    else $error("flag not low two cycles after boundary read");

  a_write_high_skew: assert property (
    ctrl_q[`MQF_CTRL_SKEW] && !ae_now && $past(ae_now) |-> ##2 !active_almost_empty_n)
    else $error("late skew release came too early");

  a_default_offset: assert property (
    ctrl_q[`MQF_CTRL_DEF] && !ctrl_q[`MQF_CTRL_DEFHI] |-> ae_lim(cur_rq_q) == `MQF_DEF_LO)
    else $error("default offset not in force");

  a_offset_bounded: assert property (
    ae_off_q[qsel_q] <= depth_q[qsel_q] || $changed(depth_q[qsel_q]) || $past(apb_wr & hit_depth))
    else $error("offset above queue depth");

  a_direct_word: assert property (
    !polled && !small_cfg && master_reset_n && $stable(word_q) |=> full_status_bus == word_bits($past(word_q))
      || $past(wr_en) || $past(rd_en))
    else $error("status word not shown one cycle after select");

  a_sync_first: assert property (
    status_bus_sync |-> polled && !full_status_bus_oe_n)
    else $error("sync high without own first word");

  a_token_pass: assert property (
    token_out |=> !$past(tok_q == mqf_pkg::MQF_TOK_OWN) || tok_q == mqf_pkg::MQF_TOK_IDLE || token_in)
    else $error("token kept after last word");

  a_mode_latch: assert property (
    !master_reset_n |=> mode_q == ($past(flag_bus_mode_sel) ? mqf_pkg::MQF_POLLED : mqf_pkg::MQF_DIRECT))
    else $error("bus mode not taken at master reset");

  a_small_cfg: assert property (
    !polled && small_cfg && $past(small_cfg) && master_reset_n && $past(master_reset_n) |-> !full_status_bus_oe_n)
    else $error("small config bus not driven");

  c_queue_switch:  cover property (read_addr_enable ##3 sel_age_q == 2'h2);
  c_poll_wrap:     cover property (token_out ##1 status_bus_sync);
  c_direct_select: cover property (full_status_strobe && id_match ##1 !full_status_bus_oe_n);

endmodule : mqf_status_flags

// >>> bench/mqf_ctrl_model.sv
// Purpose: far-side controller strapping and token ring for one device
// Assumes: single device, identity fixed by parameter
// Notes:   strap follows identity so only device zero masters the ring
`timescale 1ns/100ps
module mqf_ctrl_model #(
  parameter logic [2:0] DEV_ID = 3'h0
) (
  input  wire logic       token_out,
  output logic            token_in,
  output logic            master_strap,
  output logic [2:0]      dev_id
);
  // ----------------------------------------
  // ring wiring
  // ----------------------------------------
  // a lone device still needs the token handed back to itself
  assign token_in     = token_out;
  assign master_strap = (DEV_ID == 3'h0);
  assign dev_id       = DEV_ID;
endmodule : mqf_ctrl_model

// >>> bench/tb_top.sv
// Purpose: self-checking bench for the status flag block
// Assumes: one clock, zero-wait APB slave, single device
// Notes:   expected results queued with a target edge, checked at negedge
`timescale 1ns/100ps
`include "mqf_map.svh"
`define MQF_CHK(nm, e, o) begin n_tests++; if ((o) !== (e)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, o); end end
module tb_top;
  localparam int K_RD = 0, K_ERR = 1, K_AE = 2, K_BUS = 3, K_OE = 4, K_SYNC = 5, K_TOK = 6;
  typedef struct {int at; int k; logic [31:0] e;} mqf_note_type;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, read_queue_addr = 8'h00, write_queue_addr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, last_rd;
  logic        pready, pslverr, last_err, master_reset_n = 1'b0, flag_bus_mode_sel = 1'b0;
  logic        read_addr_enable = 1'b0, rd_en = 1'b0, write_addr_enable = 1'b0, wr_en = 1'b0;
  logic        full_status_strobe = 1'b0, token_in, master_strap, active_almost_empty_n;
  logic [7:0]  full_status_bus;
  logic [2:0]  dev_id;
  logic        full_status_bus_oe_n, status_bus_sync, token_out;
  int          cyc = 0, bad_count = 0, n_tests = 0, n, i;
  mqf_note_type q[$];
  mqf_note_type nt;
  string       nm [7] = '{"prdata", "pslverr", "almost_empty", "status_bus", "bus_oe_n", "sync", "token"};

  mqf_status_flags mqf_status_flags_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_reset_n(master_reset_n), .flag_bus_mode_sel(flag_bus_mode_sel), .master_strap(master_strap),
    .dev_id_bit0(dev_id[0]), .dev_id_bit1(dev_id[1]), .dev_id_bit2(dev_id[2]),
    .read_queue_addr(read_queue_addr), .read_addr_enable(read_addr_enable), .rd_en(rd_en),
    .write_queue_addr(write_queue_addr), .write_addr_enable(write_addr_enable), .wr_en(wr_en),
    .full_status_strobe(full_status_strobe), .token_in(token_in),
    .active_almost_empty_n(active_almost_empty_n), .full_status_bus(full_status_bus),
    .full_status_bus_oe_n(full_status_bus_oe_n), .status_bus_sync(status_bus_sync), .token_out(token_out));
  mqf_ctrl_model mqf_ctrl_model_i (.token_out(token_out), .token_in(token_in),
    .master_strap(master_strap), .dev_id(dev_id));

  // ----------------------------------------
  // clock, edge count and result watcher
  // ----------------------------------------
  always #10 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  function automatic logic [31:0] obs(input int k);
    case (k)
      K_RD:    return last_rd;
      K_ERR:   return {31'h0, last_err};
      K_AE:    return {31'h0, active_almost_empty_n};
      K_BUS:   return {24'h0, full_status_bus};
      K_OE:    return {31'h0, full_status_bus_oe_n};
      K_SYNC:  return {31'h0, status_bus_sync};
      default: return {31'h0, token_out};
    endcase
  endfunction : obs
  // notes leave in edge order, so the oldest is always due first
  always @(negedge pclk) begin
    while (q.size() > 0 && q[0].at <= cyc) begin
      nt = q.pop_front();
      `MQF_CHK(nm[nt.k], nt.e, obs(nt.k))
    end
  end

  // ----------------------------------------
  // driver tasks, each entered just after a rising edge
  // ----------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic note(input int k, input logic [31:0] e, input int d);
    q.push_back('{cyc + 1 + d, k, e});
  endtask : note
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (j = 0; j < 16; j++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (j == 16) begin bad_count++; end_sim(); end
    last_rd = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rsel(input logic [7:0] a);
    repeat (4) @(posedge pclk);
    read_queue_addr <= a; read_addr_enable <= 1'b1;
    @(posedge pclk);
    read_addr_enable <= 1'b0;
  endtask : rsel
  // queue select, two idle edges, then n writes
  task automatic wsel_wr(input logic [7:0] a, input int cnt);
    write_queue_addr <= a; write_addr_enable <= 1'b1;
    @(posedge pclk);
    write_addr_enable <= 1'b0;
    repeat (2) @(posedge pclk);
    wr_en <= 1'b1;
    repeat (cnt) @(posedge pclk);
    wr_en <= 1'b0;
    @(posedge pclk);
  endtask : wsel_wr
  task automatic one(input logic r);
    repeat (4) @(posedge pclk);
    if (r) rd_en <= 1'b1; else wr_en <= 1'b1;
    @(posedge pclk);
    rd_en <= 1'b0; wr_en <= 1'b0;
  endtask : one
  task automatic strobe(input logic [7:0] a);
    @(posedge pclk);
    write_queue_addr <= a; full_status_strobe <= 1'b1;
    @(posedge pclk);
    full_status_strobe <= 1'b0;
  endtask : strobe

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(59518));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    master_reset_n <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `MQF_OFF_CTRL, 32'h0);  note(K_RD, 32'h80, 0);
    apb(1'b0, `MQF_OFF_DEPTH, 32'h0); note(K_RD, 32'h400, 0);
    apb(1'b0, `MQF_OFF_AEOFF, 32'h0); note(K_RD, 32'h8, 0);
    apb(1'b0, 8'hFC, 32'h0); note(K_RD, 32'h0, 0); note(K_ERR, 32'h1, 0);
    rsel(8'h00); note(K_AE, 32'h0, 3);
    wsel_wr(8'h00, 9); note(K_AE, 32'h1, 3);
    one(1'b1); note(K_AE, 32'h1, 1); note(K_AE, 32'h0, 2);
    one(1'b0); note(K_AE, 32'h0, 1); note(K_AE, 32'h1, 2);
    apb(1'b1, `MQF_OFF_CTRL, 32'h280);
    one(1'b1);
    one(1'b0); note(K_AE, 32'h0, 2); note(K_AE, 32'h1, 3);
    one(1'b1);
    // skew model off again so queue switches keep the plain third-edge timing
    apb(1'b1, `MQF_OFF_CTRL, 32'h80);
    // queue 1 gets its own zero offset and a random fill
    apb(1'b1, `MQF_OFF_QSEL, 32'h1); apb(1'b1, `MQF_OFF_AEOFF, 32'h0);
    apb(1'b0, `MQF_OFF_AEOFF, 32'h0); note(K_RD, 32'h0, 0);
    n = 1 + $urandom % 6;
    wsel_wr(8'h01, n);
    apb(1'b0, `MQF_OFF_COUNT, 32'h0); note(K_RD, 32'(n), 0);
    rsel(8'h01); note(K_AE, 32'h0, 2); note(K_AE, 32'h1, 3);
    // default offset of 8 makes the lightly filled queue 1 almost empty
    apb(1'b1, `MQF_OFF_CTRL, 32'h180); note(K_AE, 32'h0, 1);
    apb(1'b1, `MQF_OFF_CTRL, 32'h80); note(K_AE, 32'h1, 1);
    rsel(8'h00); note(K_AE, 32'h1, 2); note(K_AE, 32'h0, 3);
    // direct bus: queue 8 made almost full on a short depth
    apb(1'b1, `MQF_OFF_QSEL, 32'h8); apb(1'b1, `MQF_OFF_DEPTH, 32'h10);
    wsel_wr(8'h08, 8);
    strobe(8'h01); note(K_BUS, 32'hFE, 1); note(K_OE, 32'h0, 1);
    strobe(8'h00); note(K_BUS, 32'hFF, 1);
    strobe(8'h21); note(K_OE, 32'h1, 1);
    // eight queues: word 0 driven whatever was strobed
    apb(1'b1, `MQF_OFF_CTRL, 32'h8); note(K_OE, 32'h0, 0); note(K_BUS, 32'hFF, 0);
    // polled ring with sixteen queues: two words per lap
    apb(1'b1, `MQF_OFF_CTRL, 32'h10);
    flag_bus_mode_sel <= 1'b1; master_reset_n <= 1'b0;
    repeat (2) @(posedge pclk);
    master_reset_n <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(negedge pclk);
      if (status_bus_sync === 1'b1) break;
    end
    if (i == 64) begin bad_count++; end_sim(); end
    @(posedge pclk);
    note(K_SYNC, 32'h0, 0); note(K_TOK, 32'h1, 0); note(K_OE, 32'h0, 0);
    repeat (5) @(posedge pclk);
    end_sim();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    end_sim();
  end
endmodule : tb_top
